// ==== verilog/atc_tx_cell_path.sv ====
`timescale 1ns/1ps
`default_nettype none

module atc_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8,
    parameter int CW = $clog2(DEPTH + 1)
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // Fill side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Drain side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData,
    output logic [CW-1:0] level
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    wire logic doWrite = clkEn & inValid & inReady;
    wire logic doRead = clkEn & outValid & outReady;
    wire logic [AW-1:0] wrNext = (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
    wire logic [AW-1:0] rdNext = (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
    assign inReady = (level != CW'(DEPTH));
    assign outValid = (level != '0);
    assign outData = mem[rdPtr];

    always_ff @(posedge clk) begin
        if (doWrite) begin
            mem[wrPtr] <= inData;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr <= '0;
            rdPtr <= '0;
            level <= '0;
        end else begin
            if (doWrite) wrPtr <= wrNext;
            if (doRead) rdPtr <= rdNext;
            if (doWrite != doRead) level <= doWrite ? level + 1'b1 : level - 1'b1;
        end
    end
endmodule

module atc_cell_proc #(
    parameter int TAP = 17
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // Control
    input wire logic enable,
    input wire logic testEn,
    input wire logic [31:0] testHeader,
    // Port buffer
    input wire logic [15:0] word,
    input wire logic [6:0] level,
    output logic pop,
    // Framer side
    input wire logic framerRdy,
    output logic [7:0] cellByte,
    output logic cellValid,
    output logic cellSoc,
    // Counters
    output logic [15:0] assignedCnt,
    output logic [15:0] idleCnt,
    output logic assignedWrap,
    output logic idleWrap,
    output logic cellSent
);
    import atc_pkg::*;

    function automatic logic [7:0] crcByte(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            r = {r[6:0], 1'b0} ^ ((r[7] ^ d[i]) ? CRC_POLY : 8'h00);
        end
        return r;
    endfunction

    function automatic logic [50:0] scrByte(input logic [42:0] s, input logic [7:0] d);
        logic [42:0] st;
        logic [7:0] o;
        st = s;
        o = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            o[i] = d[i] ^ st[SCR_LEN-1];
            st = {st[41:0], o[i]};
        end
        return {st, o};
    endfunction

    function automatic logic [29:0] prbsByte(input logic [21:0] p);
        logic [21:0] st;
        logic [7:0] o;
        st = p;
        o = 8'h00;
        for (int i = 7; i >= 0; i--) begin
            o[i] = st[PRBS_LEN-1] ^ st[TAP-1];
            st = {st[20:0], o[i]};
        end
        return {st, o};
    endfunction

    atc_src_e src;
    logic [5:0] byteIdx;
    logic [7:0] crc;
    logic [42:0] scr;
    logic [21:0] prbs;

    wire logic step = clkEn & enable & framerRdy;
    wire logic atStart = (byteIdx == 6'h00);
    wire logic atLast = (byteIdx == CELL_OUT_BYTES - 6'h01);
    wire logic isHec = (byteIdx == HEC_POS);
    wire logic isHdr = (byteIdx < HEC_POS);
    // A full cell is present once a cell's worth of words sits in the buffer,
    // because the buffer is always drained in whole cells.
    wire logic cellReady = (level >= 7'(CELL_WORDS));
    wire atc_src_e pickSrc = cellReady ? SRC_ASSIGNED : (testEn ? SRC_TEST : SRC_IDLE);
    wire atc_src_e curSrc = atStart ? pickSrc : src;
    wire logic [5:0] cellIdx = (byteIdx > HEC_POS) ? byteIdx - 6'h01 : byteIdx;
    wire logic [1:0] hdrSel = cellIdx[1:0];
    wire logic [7:0] idleHdr = IDLE_HEADER[8*(3-hdrSel) +: 8];
    wire logic [7:0] testHdr = testHeader[8*(3-hdrSel) +: 8];
    wire logic [29:0] prbsNext = prbsByte(prbs);
    wire logic [7:0] assignedByte = cellIdx[0] ? word[7:0] : word[15:8];
    wire logic [7:0] idleByte = isHdr ? idleHdr : IDLE_FILL;
    wire logic [7:0] testByte = isHdr ? testHdr : prbsNext[7:0];
    wire logic [7:0] rawByte = (curSrc == SRC_ASSIGNED) ? assignedByte :
                               (curSrc == SRC_TEST) ? testByte : idleByte;
    wire logic [7:0] crcNext = crcByte(atStart ? 8'h00 : crc, rawByte);
    wire logic [50:0] scrNext = scrByte(scr, rawByte);
    wire logic [7:0] outByte = isHec ? (crc ^ HEC_COSET) :
                               isHdr ? rawByte : scrNext[7:0];
    wire logic assignedDone = step & atLast & (src == SRC_ASSIGNED);
    wire logic idleDone = step & atLast & (src == SRC_IDLE);

    // The buffer is not read while the check byte goes out.
    assign pop = step & (curSrc == SRC_ASSIGNED) & ~isHec & cellIdx[0];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            src <= SRC_IDLE;
            byteIdx <= '0;
            crc <= '0;
            scr <= '0;
            prbs <= PRBS_SEED;
            cellByte <= '0;
            cellValid <= 1'b0;
            cellSoc <= 1'b0;
        end else if (clkEn) begin
            cellValid <= step;
            cellSoc <= step & atStart;
            if (!enable) begin
                byteIdx <= '0;
            end else if (step) begin
                src <= curSrc;
                cellByte <= outByte;
                byteIdx <= atLast ? 6'h00 : byteIdx + 6'h01;
                if (isHdr) crc <= crcNext;
                if (!isHdr && !isHec) scr <= scrNext[50:8];
                if (curSrc == SRC_TEST && !isHdr && !isHec) prbs <= prbsNext[29:8];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            assignedCnt <= '0;
            idleCnt <= '0;
            assignedWrap <= 1'b0;
            idleWrap <= 1'b0;
            cellSent <= 1'b0;
        end else if (clkEn) begin
            if (assignedDone) assignedCnt <= assignedCnt + 16'h0001;
            if (idleDone) idleCnt <= idleCnt + 16'h0001;
            assignedWrap <= assignedDone & (assignedCnt == 16'hFFFF);
            idleWrap <= idleDone & (idleCnt == 16'hFFFF);
            cellSent <= step & atLast;
        end
    end
endmodule

module atc_tx_cell_path (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // Configuration
    input wire logic concatMode,
    input wire logic [19:0] portAddrs,
    input wire logic [3:0] testEn,
    input wire logic [31:0] testHeader,
    // Transmit UTOPIA pins
    input wire logic txClk,
    input wire logic txEnb_n,
    input wire logic [15:0] txData,
    input wire logic [4:0] txAddr,
    input wire logic txSoc,
    input wire logic txPrty,
    output logic txClav,
    output logic txClavOe,
    // Framer side
    input wire logic [3:0] framerRdy,
    input wire logic frameTick,
    output logic [31:0] cellData,
    output logic [3:0] cellValid,
    output logic [3:0] cellSoc,
    // Host register port
    input wire logic [6:0] hostAddr,
    input wire logic hostWr,
    input wire logic hostRd,
    input wire logic [15:0] hostWData,
    output logic [15:0] hostRData
);
    import atc_pkg::*;

    // Returns {hit, port index} for a polled address.
    function automatic logic [2:0] portHit(input logic [4:0] a, input logic [19:0] pa,
                                           input logic cm);
        logic [2:0] r;
        r = 3'h0;
        for (int i = N_PORTS - 1; i >= 0; i--) begin
            if (pa[5*i +: 5] == a && (!cm || i == 0)) r = {1'b1, 2'(i)};
        end
        return r;
    endfunction

    localparam int PIN_W = 23;
    logic [2:0] clkSync;
    logic clkStable;
    logic [PIN_W-1:0] pinSync [4];
    logic [4:0] lastAddr;
    logic prevIdle;
    logic [2:0] selReg;
    logic [15:0] cellCnt;
    logic [15:0] frameCnt;
    logic [15:0] sticky [N_PORTS];

    // The link clock is only sampled; data is taken one sample older than the
    // edge so it is the value set up before the rising edge.
    wire logic linkEdge = clkSync[1] & clkSync[2] & ~clkStable;
    wire logic [PIN_W-1:0] pinNow = pinSync[3];
    wire logic pEnb_n = pinNow[22];
    wire logic pSoc = pinNow[21];
    wire logic [4:0] pAddr = pinNow[20:16];
    wire logic [15:0] pData = pinNow[15:0];
    wire logic [2:0] pollHit = portHit(pAddr, portAddrs, concatMode);
    wire logic [2:0] newSel = portHit(lastAddr, portAddrs, concatMode);
    wire logic [2:0] selNow = prevIdle ? newSel : selReg;

    wire logic linkInReady;
    wire logic linkOutValid;
    wire logic [18:0] linkOut;
    wire logic [1:0] linkPort = linkOut[18:17];
    wire logic linkWrite = linkEdge & ~pEnb_n & selNow[2];

    wire logic [3:0] portInReady;
    wire logic [15:0] portWord [N_PORTS];
    wire logic [6:0] portLevel [N_PORTS];
    wire logic [3:0] portPop;
    wire logic [15:0] assignedCnt [N_PORTS];
    wire logic [15:0] idleCnt [N_PORTS];
    wire logic [3:0] assignedWrap;
    wire logic [3:0] idleWrap;
    wire logic [3:0] cellSent;
    wire logic [3:0] procEnable = concatMode ? 4'h1 : 4'hF;
    // Room for one more cell beyond what the link buffer may still hold.
    wire logic [3:0] portRoom;
    wire logic clavNext = pollHit[2] & portRoom[pollHit[1:0]];
    wire logic [16:0] cellSum = {1'b0, cellCnt} + 17'($countones(cellSent));
    wire logic cellWrap = clkEn & cellSum[16];
    wire logic frameWrap = clkEn & frameTick & (frameCnt == 16'hFFFF);
    wire logic [6:0] rollOff = hostAddr - ROLL_BASE;
    wire logic rollHit = (hostAddr >= ROLL_BASE) && (rollOff < 7'(N_PORTS));
    wire logic [6:0] cntOff = hostAddr - CNT_ASSIGNED_BASE;
    wire logic [15:0] rdNext = rollHit ? sticky[rollOff[1:0]] :
        (cntOff < 7'h04) ? assignedCnt[cntOff[1:0]] :
        (cntOff < 7'h08) ? idleCnt[cntOff[1:0]] :
        (hostAddr == CNT_CELLS) ? cellCnt :
        (hostAddr == CNT_FRAMES) ? frameCnt : 16'h0000;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            clkSync <= '0;
            clkStable <= 1'b0;
            pinSync <= '{default: '0};
        end else if (clkEn) begin
            clkSync <= {clkSync[1:0], txClk};
            if (clkSync[1] == clkSync[2]) clkStable <= clkSync[2];
            pinSync[0] <= {txEnb_n, txSoc, txAddr, txData};
            pinSync[1] <= pinSync[0];
            pinSync[2] <= pinSync[1];
            pinSync[3] <= pinSync[2];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lastAddr <= '0;
            prevIdle <= 1'b0;
            selReg <= '0;
            txClav <= 1'b0;
            txClavOe <= 1'b0;
        end else if (clkEn && linkEdge) begin
            prevIdle <= pEnb_n;
            if (pEnb_n) lastAddr <= pAddr;
            if (!pEnb_n) selReg <= selNow;
            txClav <= clavNext;
            txClavOe <= pollHit[2];
        end
    end

    atc_fifo #(.WIDTH(19), .DEPTH(LINK_DEPTH)) linkFifo (
        .clk(clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .inValid(linkWrite),
        .inReady(linkInReady),
        .inData({selNow[1:0], pSoc, pData}),
        .outValid(linkOutValid),
        .outReady(portInReady[linkPort]),
        .outData(linkOut),
        .level()
    );

    genvar g;
    generate
        for (g = 0; g < N_PORTS; g++) begin : gPort
            wire logic [7:0] pByte;
            assign portRoom[g] = (portLevel[g] <= 7'(PORT_DEPTH - CELL_WORDS - LINK_DEPTH))
                                 & linkInReady;
            atc_fifo #(.WIDTH(16), .DEPTH(PORT_DEPTH), .CW(7)) portFifo (
                .clk(clk),
                .rst_n(rst_n),
                .clkEn(clkEn),
                .inValid(linkOutValid & (linkPort == 2'(g))),
                .inReady(portInReady[g]),
                .inData(linkOut[15:0]),
                .outValid(),
                .outReady(portPop[g]),
                .outData(portWord[g]),
                .level(portLevel[g])
            );
            atc_cell_proc #(.TAP(PRBS_TAP[g])) proc (
                .clk(clk),
                .rst_n(rst_n),
                .clkEn(clkEn),
                .enable(procEnable[g]),
                .testEn(testEn[g]),
                .testHeader(testHeader),
                .word(portWord[g]),
                .level(portLevel[g]),
                .pop(portPop[g]),
                .framerRdy(framerRdy[g]),
                .cellByte(pByte),
                .cellValid(cellValid[g]),
                .cellSoc(cellSoc[g]),
                .assignedCnt(assignedCnt[g]),
                .idleCnt(idleCnt[g]),
                .assignedWrap(assignedWrap[g]),
                .idleWrap(idleWrap[g]),
                .cellSent(cellSent[g])
            );
            assign cellData[8*g +: 8] = pByte;
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cellCnt <= '0;
            frameCnt <= '0;
        end else if (clkEn) begin
            cellCnt <= cellSum[15:0];
            if (frameTick) frameCnt <= frameCnt + 16'h0001;
        end
    end

    generate
        for (g = 0; g < N_PORTS; g++) begin : gRoll
            wire logic [15:0] setBits = (g == ROLL_REG_ASSIGNED) ? {12'h000, assignedWrap} :
                (g == ROLL_REG_IDLE) ? {12'h000, idleWrap} :
                (g == ROLL_REG_TOTAL) ? {14'h0000, frameWrap, cellWrap} : 16'h0000;
            wire logic [15:0] clrBits = (hostWr && rollHit && rollOff[1:0] == 2'(g)) ?
                                        hostWData : 16'h0000;
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    sticky[g] <= '0;
                end else if (clkEn) begin
                    sticky[g] <= (sticky[g] & ~clrBits) | setBits;
                end
            end
        end
    endgenerate

    // Reads only sample the counters; nothing is cleared on read.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hostRData <= '0;
        end else if (clkEn && hostRd) begin
            hostRData <= rdNext;
        end
    end
endmodule

`default_nettype wire

// ==== verilog/atc_pkg.sv ====
// Overview of operation
// - Twelve-channel frame mode enables all four cell processors, one stream each.
// - Concatenated frame mode enables processor 0 only; the other three stay idle.
// - Without one complete buffered cell, the processor sends an idle cell instead.
// - Header check byte is computed from the first four header bytes.
// - Header check byte goes out in the fifth byte position of the cell.
// - After header check insertion the cell payload is scrambled.
// - Each processor counts assigned cells sent and idle cells inserted separately.
// - The block also counts all cells and all frames sent.
// - Counters run freely; a host read never changes them.
// - A counter wrap sets a sticky roll-over bit at 0x52 to 0x54.
// - Sticky roll-over bits hold until host software clears them explicitly.
// - After a cell is handed to the framer, the next cell is fetched.
// - Idle cells come from the generator paired with that processor.
// - Generator may send test cells in place of idle cells.
// - Each port answers only its own programmable port address.
// - Cell words are 16 bits wide; an 8-bit path is unsupported.
// - In concatenated frame mode only port 0 is active.
// - Master may hold port 0 address so port 0 alone drives cell-available.
// - Enable, data, address and start are sampled on rising interface clock; parity is not sampled.
// - Cell-available is asserted only when the port can accept a cell.
// - Header check is CRC-8 x^8+x^2+x+1 with coset x^6+x^4+x^2+1 added.
// - The 48 payload bytes are scrambled with a self-synchronizing x^43+1 scrambler.
// - Idle cells carry header 00 00 00 01 52 and payload bytes 6A.
// - Counters are 16 bits wide with a separate 17th sticky roll-over bit.
package atc_pkg;
    localparam int N_PORTS = 4;
    localparam int WORD_W = 16;
    localparam int CELL_WORDS = 26;
    localparam logic [5:0] CELL_OUT_BYTES = 6'h35;
    localparam logic [5:0] HEC_POS = 6'h04;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] HEC_COSET = 8'h55;
    localparam logic [31:0] IDLE_HEADER = 32'h0000_0001;
    localparam logic [7:0] IDLE_FILL = 8'h6A;
    localparam int SCR_LEN = 43;
    localparam int PRBS_LEN = 22;
    localparam int PRBS_TAP [N_PORTS] = '{17, 11, 19, 14};
    localparam logic [21:0] PRBS_SEED = 22'h3FFFFF;
    localparam int LINK_DEPTH = 8;
    localparam int PORT_DEPTH = 2 * CELL_WORDS;
    localparam logic [6:0] ROLL_BASE = 7'h52;
    localparam logic [6:0] CNT_ASSIGNED_BASE = 7'h40;
    localparam logic [6:0] CNT_IDLE_BASE = 7'h44;
    localparam logic [6:0] CNT_CELLS = 7'h48;
    localparam logic [6:0] CNT_FRAMES = 7'h49;
    localparam int ROLL_REG_ASSIGNED = 0;
    localparam int ROLL_REG_IDLE = 1;
    localparam int ROLL_REG_TOTAL = 2;
    localparam int ROLL_BIT_CELLS = 0;
    localparam int ROLL_BIT_FRAMES = 1;
    localparam logic [4:0] PORT_ADDR_RST [N_PORTS] = '{5'h00, 5'h01, 5'h02, 5'h03};
    typedef enum logic [1:0] {SRC_ASSIGNED, SRC_IDLE, SRC_TEST} atc_src_e;
endpackage

// ==== test/atc_tx_cell_path_properties.sv ====
`timescale 1ns/1ps
`default_nettype none

module atc_tx_cell_path_properties (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Control and host side
    input wire logic concatMode,
    input wire logic [3:0] framerRdy,
    input wire logic [6:0] hostAddr,
    input wire logic hostRd,
    input wire logic [15:0] hostRData,
    // Framer side
    input wire logic [31:0] cellData,
    input wire logic [3:0] cellValid,
    input wire logic [3:0] cellSoc
);
    import atc_pkg::*;

    logic [5:0] byteCnt;
    logic [31:0] hdr;

    // Bit-serial model, kept apart from the design's own function.
    function automatic logic [7:0] hec_of(input logic [31:0] h);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 31; i >= 0; i--) begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ h[i]) ? 8'h07 : 8'h00);
        end
        return c ^ 8'h55;
    endfunction

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            byteCnt <= 6'h35;
            hdr <= 32'h0;
        end else if (cellValid[0]) begin
            byteCnt <= cellSoc[0] ? 6'h01 : byteCnt + 6'h01;
            hdr <= {hdr[23:0], cellData[7:0]};
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    property p_cell_len;
        cellValid[0] |-> (cellSoc[0] == (byteCnt == 6'h35));
    endproperty
    a_cell_len: assert property (p_cell_len) else $error("cell start spacing wrong");
    property p_hec;
        cellValid[0] && byteCnt == 6'h04 |-> cellData[7:0] == hec_of(hdr);
    endproperty
    a_hec: assert property (p_hec) else $error("header check byte wrong");
    property p_all_lanes;
        !concatMode |=> cellValid == $past(framerRdy);
    endproperty
    a_all_lanes: assert property (p_all_lanes) else $error("lane byte missing");
    property p_concat_lane0;
        concatMode |=> cellValid[0] == $past(framerRdy[0]);
    endproperty
    a_concat_lane0: assert property (p_concat_lane0) else $error("lane 0 stalled");
    property p_concat_quiet;
        concatMode |-> cellValid[3:1] == 3'h0;
    endproperty
    a_concat_quiet: assert property (p_concat_quiet) else $error("lane active");
    property p_unmapped;
        hostRd && hostAddr == 7'h55 |=> hostRData == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("reserved read not zero");
    property p_roll_spare;
        hostRd && hostAddr == 7'h52 |=> hostRData[15:4] == 12'h000;
    endproperty
    a_roll_spare: assert property (p_roll_spare) else $error("spare sticky bits set");
    property p_rdata_hold;
        !hostRd |=> $stable(hostRData);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

    c_hec: cover property (cellValid[0] && byteCnt == 6'h04 && hdr != 32'h1);
    c_roll: cover property (hostRd && hostAddr == 7'h54);
    c_concat: cover property (concatMode && cellSoc[0]);
endmodule

bind atc_tx_cell_path atc_tx_cell_path_properties u_props (.clk, .rst_n, .concatMode,
    .framerRdy, .hostAddr, .hostRd, .hostRData, .cellData, .cellValid, .cellSoc);

`default_nettype wire

// ==== test/atc_atm_master.sv ====
`timescale 1ns/1ps
`default_nettype none

module atc_atm_master (
    // Link pins driven by the layer
    output logic txClk,
    output logic txEnb_n,
    output logic [15:0] txData,
    output logic [4:0] txAddr,
    output logic txSoc,
    output logic txPrty,
    // Status from the port
    input wire logic txClav,
    input wire logic txClavOe
);
    initial begin
        {txClk, txEnb_n, txSoc, txPrty, txAddr, txData} = {4'h4, 5'h1F, 16'h5A5A};
        #37;
        forever #200 txClk = ~txClk;
    end

    // Data is not held while disabled, so a port that stores it misaligns the cell.
    always @(posedge txClk) begin
        #1;
        if (txEnb_n) txData = ~txData;
    end

    task automatic poll(input logic [4:0] a, output logic clav, output logic oe);
        @(posedge txClk);
        #2;
        txAddr = a;
        @(posedge txClk);
        @(posedge txClk);
        clav = txClav;
        oe = txClavOe;
    endtask

    task automatic send_cell(input logic [4:0] a, input logic [31:0] h, output logic ok);
        int n;
        n = 0;
        ok = 1'b0;
        @(posedge txClk);
        #2;
        txAddr = a;
        @(posedge txClk);
        while (n < 40 && !ok) begin
            @(posedge txClk);
            ok = (txClav === 1'b1) && (txClavOe === 1'b1);
            n++;
        end
        for (int w = 0; w < 26 && ok; w++) begin
            #2;
            txEnb_n = 1'b0;
            txSoc = (w == 0);
            txData = (w == 0) ? h[31:16] : (w == 1) ? h[15:0] : {8'(2 * w), 8'(2 * w + 1)};
            txPrty = ^txData;
            @(posedge txClk);
        end
        #2;
        txEnb_n = 1'b1;
        txSoc = 1'b0;
    endtask
endmodule

`default_nettype wire

// ==== test/atc_tx_cell_path_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none

`define CHK(act, exp) begin checked++; if ((act) !== (exp)) begin mismatches++; \
    $display("[ERR] %0t got %h exp %h", $time, (act), (exp)); end end

module atc_tx_cell_path_tb_top;
    import atc_pkg::*;

    logic clk = 1'b0;
    logic rst_n, clkEn, concatMode, frameTick, hostWr, hostRd, clav, oe, ok;
    logic txClk, txEnb_n, txSoc, txPrty, txClav, txClavOe;
    logic [19:0] portAddrs;
    logic [3:0] testEn, framerRdy, cellValid, cellSoc, seen;
    logic [31:0] testHeader, cellData;
    logic [6:0] hostAddr;
    logic [15:0] hostWData, hostRData, txData, a0, a1;
    logic [4:0] txAddr;
    logic [7:0] cur [53], last [53];
    logic [7:0] rawB, plainB;
    logic [42:0] hist = 43'h0;
    int idx = 0, checked = 0, mismatches = 0;

    always #25 clk = ~clk;

    atc_tx_cell_path dut (.clk, .rst_n, .clkEn, .concatMode, .portAddrs, .testEn, .testHeader,
        .txClk, .txEnb_n, .txData, .txAddr, .txSoc, .txPrty, .txClav, .txClavOe, .framerRdy,
        .frameTick, .cellData, .cellValid, .cellSoc, .hostAddr, .hostWr, .hostRd, .hostWData,
        .hostRData);

    atc_atm_master u_master (.txClk, .txEnb_n, .txData, .txAddr, .txSoc, .txPrty, .txClav,
        .txClavOe);

    // Lane 0 monitor: descrambles the payload; header bytes pass as sent.
    always @(posedge clk) begin
        if (cellValid[0] === 1'b1) begin
            if (cellSoc[0] === 1'b1) idx = 0;
            rawB = cellData[7:0];
            plainB = rawB;
            for (int j = 7; j >= 0 && idx >= 5; j--) begin
                plainB[j] = rawB[j] ^ hist[42];
                hist = {hist[41:0], rawB[j]};
            end
            if (idx < 53) cur[idx] = plainB;
            if (idx == 52) last = cur;
            idx++;
        end
    end

    task automatic end_sim();
        $display("checked=%0d mismatches=%0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic do_reset(input logic cm);
        rst_n = 1'b0;
        concatMode = cm;
        repeat (12) @(posedge clk);
        #2;
        rst_n = 1'b1;
        repeat (2) @(posedge clk);
        #2;
    endtask

    task automatic acc(input logic [6:0] a, output logic [15:0] d, input logic w = 1'b0,
                       input logic [15:0] wd = 16'h0000);
        @(posedge clk);
        #2;
        hostAddr = a;
        hostWData = wd;
        hostWr = w;
        hostRd = !w;
        @(posedge clk);
        #2;
        {hostWr, hostRd} = 2'b00;
        d = hostRData;
    endtask

    task automatic wait_cell(input logic [31:0] h, input int mode);
        int n;
        n = 0;
        last[0] = 8'hFF;
        while (n < 2000 && {last[0], last[1], last[2], last[3]} !== h) begin
            @(posedge clk);
            n++;
        end
        #2;
        `CHK({last[0], last[1], last[2], last[3]}, h)
        for (int i = 5; i < 53; i++) begin
            if (mode == 1) `CHK(last[i], 8'h6A)
            if (mode == 2) `CHK(last[i], 8'(i - 1))
        end
    endtask

    task automatic lanes(input logic [3:0] exp);
        seen = 4'h0;
        repeat (120) begin
            @(posedge clk);
            #2;
            seen = seen | cellSoc;
        end
        `CHK(seen, exp)
    endtask

    task automatic test_cells();
        repeat (300) @(posedge clk);
        wait_cell(32'h0000_0001, 1);
        `CHK(last[4], 8'h52)
        u_master.poll(5'h1F, clav, oe);
        `CHK(oe, 1'b0)
        u_master.poll(5'h0C, clav, oe);
        `CHK({oe, clav}, 2'b11)
        lanes(4'hF);
        $display("test_cells done");
    endtask

    task automatic test_flow();
        acc(7'h40, a0);
        framerRdy = 4'hE;
        u_master.send_cell(5'h0A, 32'h0012_3450, ok);
        u_master.poll(5'h0A, clav, oe);
        `CHK({ok, clav}, 2'b10)
        @(posedge clk);
        #2;
        framerRdy = 4'hF;
        wait_cell(32'h0012_3450, 2);
        acc(7'h40, a1);
        `CHK(a1, a0 + 16'h0001)
        testHeader = 32'h0ABC_DEF0;
        testEn = 4'h1;
        wait_cell(32'h0ABC_DEF0, 0);
        acc(7'h44, a0);
        wait_cell(32'h0ABC_DEF0, 0);
        acc(7'h44, a1);
        `CHK(a1, a0)
        u_master.send_cell(5'h0A, 32'h0034_5670, ok);
        wait_cell(32'h0034_5670, 2);
        testEn = 4'h0;
        $display("test_flow done");
    endtask

    task automatic test_counters();
        framerRdy = 4'h0;
        repeat (60) @(posedge clk);
        acc(7'h44, a0);
        acc(7'h44, a1);
        `CHK({a1 == a0, a0 != 16'h0}, 2'b11)
        acc(7'h49, a0);
        frameTick = 1'b1;
        repeat (17'h1_0003 - {1'b0, a0}) @(posedge clk);
        #2;
        frameTick = 1'b0;
        acc(7'h49, a1);
        `CHK(a1, 16'h0003)
        acc(7'h54, a1);
        acc(7'h54, a0, 1'b1);
        acc(7'h54, a0);
        `CHK({a1[1], a0[1]}, 2'b11)
        acc(7'h54, a0, 1'b1, 16'h0002);
        acc(7'h54, a0);
        acc(7'h55, a1);
        acc(7'h52, a1);
        `CHK(a0[1], 1'b0)
        $display("test_counters done");
    endtask

    task automatic test_concat();
        framerRdy = 4'hF;
        do_reset(1'b1);
        lanes(4'h1);
        u_master.poll(5'h0B, clav, oe);
        `CHK(oe, 1'b0)
        u_master.send_cell(5'h0A, 32'h0056_7890, ok);
        wait_cell(32'h0056_7890, 2);
        $display("test_concat done");
    endtask

    initial begin
        {rst_n, clkEn, concatMode, frameTick, hostWr, hostRd} = 6'h10;
        portAddrs = {5'h0D, 5'h0C, 5'h0B, 5'h0A};
        {testEn, framerRdy, testHeader, hostAddr, hostWData} = {8'h0F, 55'h0};
        do_reset(1'b0);
        test_cells();
        test_flow();
        test_counters();
        test_concat();
        end_sim();
    end

    initial begin
        repeat (90000) @(posedge clk);
        mismatches++;
        end_sim();
    end
endmodule

`default_nettype wire
